/* File: fss_pkg.sv */
// Shared constants for the fixed setpoint selector and motorized potentiometer
package fss_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int VAL_W = 16;
    localparam int SUM_W = 18;
    localparam int ADDR_W = 8;
    localparam int ROUTE_W = 5;
    localparam int FUNC_W = 7;
    localparam int NUM_FIXED = 7;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_SRC_SEL = 8'h00;
    localparam logic [7:0] OFS_CMD_SEL = 8'h04;
    localparam logic [7:0] OFS_MAIN_ROUTE = 8'h08;
    localparam logic [7:0] OFS_SUPP_ROUTE = 8'h0C;
    localparam logic [7:0] OFS_IN_FUNC = 8'h10;
    localparam logic [7:0] OFS_METHOD = 8'h14;
    localparam logic [7:0] OFS_SEL_ROUTE = 8'h18;
    localparam logic [7:0] OFS_POT_ROUTE = 8'h1C;
    localparam logic [7:0] OFS_FIXED_BASE = 8'h20;
    localparam logic [7:0] OFS_FIXED_LAST = 8'h38;
    localparam logic [7:0] OFS_FIXED_OUT = 8'h40;
    localparam logic [7:0] OFS_POT_OUT = 8'h44;
    localparam logic [7:0] OFS_STATUS = 8'h48;
    localparam logic [7:0] OFS_CMD_WORD = 8'h4C;
    localparam logic [7:0] OFS_POT_STEP = 8'h50;

    // ----------------------------------------
    // Field positions (three channels packed per word)
    // ----------------------------------------
    localparam int POS_CH_ONE = 0;
    localparam int POS_CH_TWO = 8;
    localparam int POS_CH_THREE = 16;
    localparam int POS_STAT_RUN = 3;

    // ----------------------------------------
    // Codes
    // ----------------------------------------
    localparam logic [3:0] SRC_MOTOR_POT = 4'h1;
    localparam logic [3:0] SRC_FIXED = 4'h3;
    localparam logic [1:0] ROUTE_ZERO = 2'h0;
    localparam logic [1:0] ROUTE_FIXED = 2'h1;
    localparam logic [1:0] ROUTE_MOTOR_POT = 2'h2;
    localparam logic [6:0] FUNC_DIRECT_RUN = 7'h10;
    localparam logic [6:0] FUNC_BINARY_RUN = 7'h11;
    localparam logic [6:0] FUNC_FREE = 7'h63;
    localparam logic [1:0] METHOD_DIRECT_RUN = 2'h2;
    localparam logic [1:0] METHOD_BINARY_RUN = 2'h3;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [3:0] SRC_SEL_RST = 4'h0;
    localparam logic [1:0] ROUTE_RST = 2'h0;
    localparam logic [6:0] FUNC_RST = 7'h00;
    localparam logic [1:0] METHOD_RST = 2'h1;
    localparam logic [4:0] SRC_ROUTE_RST = 5'h00;
    localparam logic [15:0] FIXED_VAL_RST = 16'h0000;
    localparam logic [15:0] POT_STEP_RST = 16'h0001;

    // ----------------------------------------
    // Timing: potentiometer ramp tick
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int POT_TICK_NS = 1000;
    localparam int POT_TICK_CYC = (POT_TICK_NS / CLK_PERIOD_NS < 1) ? 1
                                  : POT_TICK_NS / CLK_PERIOD_NS;
endpackage

/* File: sel_source_mux.sv */
// Picks one control level from a synchronised pin or a bit of the command word
`timescale 1ns/1ps
module sel_source_mux (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    input wire logic [15:0] cmd_word,
    input wire logic [4:0] route,
    output logic level
);
    import fss_pkg::*;

    logic sync1_r;
    logic sync2_r;
    logic level_nxt;

    // Pin passes two flops; first stage is read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin;
            sync2_r <= sync1_r;
        end
    end

    // Bit 4 of the route chooses the command word, bits 3:0 its bit
    assign level_nxt = route[4] ? cmd_word[route[3:0]] : sync2_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 1'b0;
        end else begin
            level <= level_nxt;
        end
    end
endmodule

/* File: motor_pot.sv */
// Emulated motorized potentiometer: ramps on raise or lower alone, holds otherwise
`timescale 1ns/1ps
module motor_pot #(
    parameter int VAL_W = fss_pkg::VAL_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic raise,
    input wire logic lower,
    input wire logic [VAL_W-1:0] step,
    output logic [VAL_W-1:0] value
);
    import fss_pkg::*;

    logic [VAL_W:0] up_sum;
    logic [VAL_W-1:0] up_nxt;
    logic [VAL_W-1:0] down_nxt;
    logic [VAL_W-1:0] value_nxt;

    // Saturate at both ends so a held key never wraps the setpoint
    assign up_sum = {1'b0, value} + {1'b0, step};
    assign up_nxt = up_sum[VAL_W] ? {VAL_W{1'b1}} : up_sum[VAL_W-1:0];
    assign down_nxt = (value > step) ? value - step : '0;
    assign value_nxt = (raise && !lower) ? up_nxt
                     : (lower && !raise) ? down_nxt
                     : value;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value <= '0;
        end else if (tick) begin
            value <= value_nxt;
        end
    end
endmodule

/* File: fixed_setpoint_selector.sv */
// Fixed setpoint selector with motorized potentiometer entry, APB registers
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module fixed_setpoint_selector #(
    parameter int POT_TICK_CYC = fss_pkg::POT_TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fss_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sel_input_one,
    input wire logic sel_input_two,
    input wire logic sel_input_three,
    input wire logic raise_pin,
    input wire logic lower_pin,
    output logic [fss_pkg::SUM_W-1:0] fixed_setpoint_out,
    output logic [fss_pkg::VAL_W-1:0] motor_pot_out,
    output logic [fss_pkg::SUM_W-1:0] main_setpoint,
    output logic [fss_pkg::SUM_W-1:0] supp_setpoint,
    output logic run_cmd
);
    import fss_pkg::*;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [3:0] setpoint_source_select_r;
    logic [3:0] command_setpoint_select_r;
    logic [1:0] main_setpoint_route_r;
    logic [1:0] supp_setpoint_route_r;
    logic [FUNC_W-1:0] in_func_r [0:2];
    logic [1:0] fixed_freq_method_r;
    logic [ROUTE_W-1:0] fixed_sel_route_r [0:2];
    logic [ROUTE_W-1:0] raise_route_r;
    logic [ROUTE_W-1:0] lower_route_r;
    logic [VAL_W-1:0] fixed_val_r [1:NUM_FIXED];
    logic [15:0] cmd_word_r;
    logic [VAL_W-1:0] pot_step_r;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic setup_ph;
    logic wr_fire;
    logic in_fixed;
    logic [2:0] fixed_idx;
    logic mapped;
    logic [31:0] rd_mux;

    assign setup_ph = psel && !penable;
    // Writes land on the access edge where our own pready is high
    assign wr_fire = psel && penable && pwrite && pready && !pslverr;
    assign in_fixed = (paddr >= OFS_FIXED_BASE) && (paddr <= OFS_FIXED_LAST)
                      && (paddr[1:0] == 2'b00);
    assign fixed_idx = 3'(((paddr - OFS_FIXED_BASE) >> 2) + 8'h01);
    assign mapped = in_fixed || paddr == OFS_SRC_SEL || paddr == OFS_CMD_SEL
                    || paddr == OFS_MAIN_ROUTE || paddr == OFS_SUPP_ROUTE
                    || paddr == OFS_IN_FUNC || paddr == OFS_METHOD
                    || paddr == OFS_SEL_ROUTE || paddr == OFS_POT_ROUTE
                    || paddr == OFS_FIXED_OUT || paddr == OFS_POT_OUT
                    || paddr == OFS_STATUS || paddr == OFS_CMD_WORD
                    || paddr == OFS_POT_STEP;

    // ----------------------------------------
    // Selection sources
    // ----------------------------------------
    logic [2:0] sel_pins;
    logic [2:0] sel_lvl;
    logic raise_lvl;
    logic lower_lvl;

    assign sel_pins = {sel_input_three, sel_input_two, sel_input_one};

    // Each selection bit comes from its pin or a command word bit
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sel
            sel_source_mux u_sel (
                .pclk(pclk),
                .presetn(presetn),
                .pin(sel_pins[g]),
                .cmd_word(cmd_word_r),
                .route(fixed_sel_route_r[g]),
                .level(sel_lvl[g])
            );
        end
    endgenerate

    sel_source_mux u_raise (
        .pclk(pclk),
        .presetn(presetn),
        .pin(raise_pin),
        .cmd_word(cmd_word_r),
        .route(raise_route_r),
        .level(raise_lvl)
    );

    sel_source_mux u_lower (
        .pclk(pclk),
        .presetn(presetn),
        .pin(lower_pin),
        .cmd_word(cmd_word_r),
        .route(lower_route_r),
        .level(lower_lvl)
    );

    // ----------------------------------------
    // Method per input and fixed value selection
    // ----------------------------------------
    logic [2:0] is_binary;
    logic [2:0] is_direct_run;
    logic [SUM_W-1:0] direct_sum;
    logic [SUM_W-1:0] binary_val;
    logic [SUM_W-1:0] fixed_nxt;
    logic binary_mode;
    logic run_nxt;

    // Code 16/17 fix the method, code 99 defers to the method field
    generate
        for (g = 0; g < 3; g++) begin : g_mode
            assign is_binary[g] = in_func_r[g] == FUNC_BINARY_RUN
                || (in_func_r[g] == FUNC_FREE
                    && fixed_freq_method_r == METHOD_BINARY_RUN);
            assign is_direct_run[g] = in_func_r[g] == FUNC_DIRECT_RUN
                || (in_func_r[g] == FUNC_FREE
                    && fixed_freq_method_r == METHOD_DIRECT_RUN);
        end
    endgenerate

    // Input one decides between the two coding schemes
    assign binary_mode = is_binary[0];

    // Each active signal adds its own value; the sum cannot overflow SUM_W
    assign direct_sum = (sel_lvl[0] ? SUM_W'(fixed_val_r[1]) : '0)
                      + (sel_lvl[1] ? SUM_W'(fixed_val_r[2]) : '0)
                      + (sel_lvl[2] ? SUM_W'(fixed_val_r[3]) : '0);

    // Signal three is the top bit of the index, index zero is zero
    assign binary_val = (sel_lvl == 3'b000) ? '0
                      : SUM_W'(fixed_val_r[sel_lvl]);

    assign fixed_nxt = binary_mode ? binary_val : direct_sum;

    // Binary run needs all three inputs in binary mode; plain direct never runs
    assign run_nxt = binary_mode ? (&is_binary) && (|sel_lvl)
                   : |(sel_lvl & is_direct_run);

    // ----------------------------------------
    // Outputs and routing
    // ----------------------------------------
    logic tick;
    logic [$clog2(POT_TICK_CYC+1)-1:0] tick_cnt_r;
    logic [SUM_W-1:0] main_nxt;
    logic [SUM_W-1:0] supp_nxt;
    logic [VAL_W-1:0] pot_value;

    // Fixed setpoint and run follow the live levels each cycle, no latching
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fixed_setpoint_out <= '0;
            run_cmd <= 1'b0;
        end else begin
            fixed_setpoint_out <= fixed_nxt;
            run_cmd <= run_nxt;
        end
    end

    // Divider gives the ramp enable pulse
    assign tick = tick_cnt_r == ($bits(tick_cnt_r))'(POT_TICK_CYC - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
        end
    end

    motor_pot #(
        .VAL_W(VAL_W)
    ) u_pot (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .raise(raise_lvl),
        .lower(lower_lvl),
        .step(pot_step_r),
        .value(pot_value)
    );

    assign main_nxt = (main_setpoint_route_r == ROUTE_FIXED) ? fixed_nxt
                    : (main_setpoint_route_r == ROUTE_MOTOR_POT) ? SUM_W'(pot_value)
                    : '0;
    assign supp_nxt = (supp_setpoint_route_r == ROUTE_FIXED) ? fixed_nxt
                    : (supp_setpoint_route_r == ROUTE_MOTOR_POT) ? SUM_W'(pot_value)
                    : '0;

    // Routed setpoints, one flop stage like the fixed output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_pot_out <= '0;
            main_setpoint <= '0;
            supp_setpoint <= '0;
        end else begin
            motor_pot_out <= pot_value;
            main_setpoint <= main_nxt;
            supp_setpoint <= supp_nxt;
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    logic src_wr;
    logic [3:0] src_code;

    assign src_wr = wr_fire && paddr == OFS_SRC_SEL;
    assign src_code = pwdata[3:0];

    // Source select codes 3 and 1 rewrite both routes, others keep them; a direct route write in the same
    // transfer is impossible since one transfer hits one address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setpoint_source_select_r <= SRC_SEL_RST;
            main_setpoint_route_r <= ROUTE_RST;
            supp_setpoint_route_r <= ROUTE_RST;
        end else if (src_wr) begin
            setpoint_source_select_r <= src_code;
            if (src_code == SRC_FIXED) begin
                main_setpoint_route_r <= ROUTE_FIXED;
                supp_setpoint_route_r <= ROUTE_ZERO;
            end else if (src_code == SRC_MOTOR_POT) begin
                main_setpoint_route_r <= ROUTE_MOTOR_POT;
                supp_setpoint_route_r <= ROUTE_ZERO;
            end
        end else if (wr_fire && paddr == OFS_MAIN_ROUTE) begin
            main_setpoint_route_r <= pwdata[1:0];
        end else if (wr_fire && paddr == OFS_SUPP_ROUTE) begin
            supp_setpoint_route_r <= pwdata[1:0];
        end
    end

    // Plain configuration words; command selector is stored only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_setpoint_select_r <= SRC_SEL_RST;
            fixed_freq_method_r <= METHOD_RST;
            raise_route_r <= SRC_ROUTE_RST;
            lower_route_r <= SRC_ROUTE_RST;
            cmd_word_r <= '0;
            pot_step_r <= POT_STEP_RST;
        end else if (wr_fire) begin
            if (paddr == OFS_CMD_SEL) command_setpoint_select_r <= pwdata[3:0];
            if (paddr == OFS_METHOD) fixed_freq_method_r <= pwdata[1:0];
            if (paddr == OFS_POT_ROUTE) raise_route_r <= pwdata[4:0];
            if (paddr == OFS_POT_ROUTE) lower_route_r <= pwdata[12:8];
            if (paddr == OFS_CMD_WORD) cmd_word_r <= pwdata[15:0];
            if (paddr == OFS_POT_STEP) pot_step_r <= pwdata[VAL_W-1:0];
        end
    end

    // Per-input function codes and selection routes, packed per channel
    generate
        for (g = 0; g < 3; g++) begin : g_cfg
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    in_func_r[g] <= FUNC_RST;
                    fixed_sel_route_r[g] <= SRC_ROUTE_RST;
                end else if (wr_fire && paddr == OFS_IN_FUNC) begin
                    in_func_r[g] <= pwdata[g*8 +: FUNC_W];
                end else if (wr_fire && paddr == OFS_SEL_ROUTE) begin
                    fixed_sel_route_r[g] <= pwdata[g*8 +: ROUTE_W];
                end
            end
        end
        for (g = 1; g <= NUM_FIXED; g++) begin : g_val
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fixed_val_r[g] <= FIXED_VAL_RST;
                end else if (wr_fire && in_fixed && fixed_idx == 3'(g)) begin
                    fixed_val_r[g] <= pwdata[VAL_W-1:0];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Read mux and APB response
    // ----------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (in_fixed) begin
            rd_mux = 32'(fixed_val_r[fixed_idx]);
        end else begin
            case (paddr)
                OFS_SRC_SEL: rd_mux = 32'(setpoint_source_select_r);
                OFS_CMD_SEL: rd_mux = 32'(command_setpoint_select_r);
                OFS_MAIN_ROUTE: rd_mux = 32'(main_setpoint_route_r);
                OFS_SUPP_ROUTE: rd_mux = 32'(supp_setpoint_route_r);
                OFS_IN_FUNC: rd_mux = {8'h00, 1'b0, in_func_r[2], 1'b0, in_func_r[1],
                                       1'b0, in_func_r[0]};
                OFS_METHOD: rd_mux = 32'(fixed_freq_method_r);
                OFS_SEL_ROUTE: rd_mux = {11'h000, fixed_sel_route_r[2], 3'h0,
                                         fixed_sel_route_r[1], 3'h0, fixed_sel_route_r[0]};
                OFS_POT_ROUTE: rd_mux = {19'h00000, lower_route_r, 3'h0, raise_route_r};
                OFS_FIXED_OUT: rd_mux = 32'(fixed_setpoint_out);
                OFS_POT_OUT: rd_mux = 32'(motor_pot_out);
                OFS_STATUS: rd_mux = {28'h0000000, run_cmd, sel_lvl};
                OFS_CMD_WORD: rd_mux = 32'(cmd_word_r);
                OFS_POT_STEP: rd_mux = 32'(pot_step_r);
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Answer is ready in the first access cycle; data captured at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup_ph) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= (mapped && !pwrite) ? rd_mux : 32'h0000_0000;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule

/* File: sel_pin_source.sv */
// Partner model: outside contacts for the selection and potentiometer pins
`timescale 1ns/1ps
module sel_pin_source (
    input wire logic pclk,
    input wire logic [4:0] want,
    output logic [2:0] sel,
    output logic raise,
    output logic lower
);
    // ----------------------------------------
    // Contacts
    // ----------------------------------------
    // Levels move just after an edge, as an outside device would switch them
    always @(posedge pclk) begin
        {lower, raise, sel} <= want;
    end
endmodule

/* File: fss_checker_properties.sv */
// Port checker for the fixed setpoint selector
`timescale 1ns/1ps
module fss_checker #(
    parameter int POT_TICK_CYC = fss_pkg::POT_TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sel_input_one,
    input wire logic sel_input_two,
    input wire logic sel_input_three,
    input wire logic raise_pin,
    input wire logic lower_pin,
    input wire logic [fss_pkg::VAL_W-1:0] motor_pot_out,
    input wire logic [fss_pkg::SUM_W-1:0] main_setpoint,
    input wire logic run_cmd
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    // Run can only stem from a selection level seen a few edges earlier
    logic any_sel;
    assign any_sel = sel_input_one | sel_input_two | sel_input_three;
    // Edges with raise alone in a row; long enough to span a tick at any divider
    int raise_run;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raise_run <= 0;
        end else begin
            raise_run <= (raise_pin && !lower_pin) ? raise_run + 1 : 0;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray pready");
    a_error_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
    a_error_reads_zero: assert property (pslverr |-> prdata == 32'h0000_0000)
        else $error("error data not zero");
    a_run_needs_sel: assert property (run_cmd |-> $past(any_sel, 3) || $past(any_sel, 4)
        || $past(any_sel, 5)) else $error("run without selection");
    a_pot_frozen: assert property ((raise_pin == lower_pin)[*8] |-> $stable(motor_pot_out))
        else $error("pot moved while frozen");
    a_pot_raise_up: assert property ((raise_pin && !lower_pin)[*8] |-> motor_pot_out >=
        $past(motor_pot_out)) else $error("pot fell on raise");
    a_pot_lower_down: assert property ((lower_pin && !raise_pin)[*8] |-> motor_pot_out <=
        $past(motor_pot_out)) else $error("pot rose on lower");
    a_pot_moves: assert property (raise_run >= 2 * POT_TICK_CYC + 6 && motor_pot_out < 16'hFF00
        |-> motor_pot_out != $past(motor_pot_out, 2 * POT_TICK_CYC + 2)) else $error("pot stuck");
    // Main scenarios reached
    c_error: cover property (pslverr);
    c_run: cover property ($rose(run_cmd));
    c_pot: cover property ($rose(motor_pot_out != 16'h0000));
    c_main: cover property (main_setpoint != 18'h00000);
endmodule
bind fixed_setpoint_selector fss_checker #(.POT_TICK_CYC(POT_TICK_CYC)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sel_input_one(sel_input_one),
    .sel_input_two(sel_input_two), .sel_input_three(sel_input_three), .raise_pin(raise_pin),
    .lower_pin(lower_pin), .motor_pot_out(motor_pot_out), .main_setpoint(main_setpoint),
    .run_cmd(run_cmd));

/* File: fixed_setpoint_selector_tb_top.sv */
// Self-checking bench for the fixed setpoint selector
`timescale 1ns/1ps
module fixed_setpoint_selector_tb_top;
    import fss_pkg::*;
    typedef struct packed {
        logic [6:0] code;
        logic [1:0] method;
        logic [2:0] sel;
        logic [17:0] out;
        logic run;
    } row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] want = 5'h00;
    logic [2:0] sel;
    logic raise_pin;
    logic lower_pin;
    logic [17:0] fixed_out;
    logic [15:0] pot_out;
    logic [17:0] main_sp;
    logic [17:0] supp_sp;
    logic run_cmd;
    logic [31:0] rdata;
    logic rerr;
    logic [15:0] held;
    int miscompares = 0;
    int num_checks = 0;
    // Fixed value k is k * 1111h, so every sum and index is easy to see
    row_t rows [10] = '{'{7'h00, 2'h1, 3'b011, 18'h03333, 1'b0},
        '{7'h00, 2'h1, 3'b111, 18'h06666, 1'b0}, '{7'h10, 2'h1, 3'b100, 18'h03333, 1'b1},
        '{7'h10, 2'h1, 3'b101, 18'h04444, 1'b1}, '{7'h10, 2'h1, 3'b000, 18'h00000, 1'b0},
        '{7'h11, 2'h1, 3'b110, 18'h06666, 1'b1}, '{7'h11, 2'h1, 3'b001, 18'h01111, 1'b1},
        '{7'h11, 2'h1, 3'b000, 18'h00000, 1'b0}, '{7'h63, 2'h2, 3'b010, 18'h02222, 1'b1},
        '{7'h63, 2'h3, 3'b011, 18'h03333, 1'b1}};
    // ----------------------------------------
    // Set-up
    // ----------------------------------------
    always #10 pclk = ~pclk;
    fixed_setpoint_selector #(.POT_TICK_CYC(2)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sel_input_one(sel[0]), .sel_input_two(sel[1]), .sel_input_three(sel[2]),
        .raise_pin(raise_pin), .lower_pin(lower_pin), .fixed_setpoint_out(fixed_out),
        .motor_pot_out(pot_out), .main_setpoint(main_sp), .supp_setpoint(supp_sp),
        .run_cmd(run_cmd));
    sel_pin_source u_src (.pclk(pclk), .want(want), .sel(sel), .raise(raise_pin),
        .lower(lower_pin));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One APB transfer; the request stands until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // A slave that never answers ends the run at the verdict
        if (n >= 20) begin
            miscompares++;
            final_report;
        end
    endtask
    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, exp, rdata);
    endtask
    task final_report;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #200000;
        miscompares++;
        final_report;
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("method reset", OFS_METHOD, 32'h0000_0001);
        for (int k = 1; k <= 7; k++) begin
            apb(1'b1, 8'(OFS_FIXED_BASE + 4 * (k - 1)), 32'(k * 16'h1111));
        end
        rdchk("fixed seven", OFS_FIXED_LAST, 32'h0000_7777);
        apb(1'b1, OFS_CMD_SEL, 32'h0000_0003);
        rdchk("main kept", OFS_MAIN_ROUTE, 32'h0000_0000);
        apb(1'b1, OFS_SRC_SEL, 32'h0000_0003);
        rdchk("main fixed", OFS_MAIN_ROUTE, 32'h0000_0001);
        rdchk("supp zero", OFS_SUPP_ROUTE, 32'h0000_0000);
        foreach (rows[i]) begin
            apb(1'b1, OFS_IN_FUNC, {9'h000, rows[i].code, 1'b0, rows[i].code, 1'b0, rows[i].code});
            apb(1'b1, OFS_METHOD, {30'h0, rows[i].method});
            want <= {2'b00, rows[i].sel};
            repeat (8) @(posedge pclk);
            chk("fixed out", rows[i].out, fixed_out);
            chk("run", rows[i].run, run_cmd);
            chk("main", rows[i].out, main_sp);
        end
        // Only input one binary: the run must stay off
        apb(1'b1, OFS_IN_FUNC, 32'h0000_0011);
        want <= 5'h01;
        repeat (8) @(posedge pclk);
        chk("partial binary", 32'h0, run_cmd);
        // Selection taken from a command word bit while the pins rest
        apb(1'b1, OFS_IN_FUNC, 32'h0000_0000);
        apb(1'b1, OFS_SEL_ROUTE, 32'h0000_0010);
        apb(1'b1, OFS_CMD_WORD, 32'h0000_0001);
        want <= 5'h00;
        repeat (8) @(posedge pclk);
        chk("word select", 32'h0000_1111, fixed_out);
        // Supplementary route picks the fixed output too
        apb(1'b1, OFS_SUPP_ROUTE, 32'h0000_0001);
        repeat (4) @(posedge pclk);
        chk("supp fixed", 32'h0000_1111, supp_sp);
        apb(1'b0, 8'hFC, 32'h0000_0000);
        chk("unmapped err", 32'h1, rerr);
        chk("unmapped data", 32'h0, rdata);
        // Potentiometer: raise, freeze with both, lower to the floor
        apb(1'b1, OFS_MAIN_ROUTE, 32'h0000_0002);
        want <= 5'h08;
        repeat (40) @(posedge pclk);
        chk("pot raised", 32'h1, pot_out != 16'h0000);
        want <= 5'h18;
        repeat (10) @(posedge pclk);
        held = pot_out;
        repeat (20) @(posedge pclk);
        chk("pot frozen", held, pot_out);
        chk("main pot", pot_out, main_sp);
        want <= 5'h10;
        repeat (80) @(posedge pclk);
        chk("pot lowered", 32'h0, pot_out);
        final_report;
    end
endmodule
